// ### ppr_pkg.sv
// ppr_pkg: constants, types and the address decoder shared by the printer port register block.
// assumes one clock domain; every host and printer pin is synchronous to that clock.
`default_nettype none

package ppr_pkg;

    // register addresses on the two host address bits
    localparam logic [1:0] ADDR_DATA    = 2'h0;
    localparam logic [1:0] ADDR_STATUS  = 2'h1;
    localparam logic [1:0] ADDR_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_INVALID = 2'h3;

    // status register field positions
    localparam int ST_FAULT  = 3;
    localparam int ST_ONLINE = 4;
    localparam int ST_MEDIA  = 5;
    localparam int ST_DONE   = 6;
    localparam int ST_BUSY   = 7;
    localparam logic [7:0] ST_ONES = 8'h07;

    // control register field positions
    localparam int CTL_STROBE = 0;
    localparam int CTL_FEED   = 1;
    localparam int CTL_INIT   = 2;
    localparam int CTL_SELECT = 3;
    localparam int CTL_IRQ_EN = 4;
    localparam logic [7:0] CTL_ONES = 8'hE0;

    // values after reset: data lines low, every control pin at its idle high level, irq pin off
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [4:0] CTL_RESET   = 5'h00;
    localparam logic [7:0] READ_IDLE   = 8'h00;

    // which register a host address selects
    typedef enum logic [1:0] {
        PPR_TGT_DATA,
        PPR_TGT_STATUS,
        PPR_TGT_CONTROL,
        PPR_TGT_NONE
    } ppr_target_t;

    // host bus as sampled at a clock edge
    typedef struct packed {
        logic       sel_n;
        logic       rd_n;
        logic       wr_n;
        logic [1:0] addr;
        logic [7:0] wdata;
    } ppr_host_req_t;

    // sensed printer status inputs
    typedef struct packed {
        logic fault_n;
        logic online;
        logic media_out;
        logic ack_n;
        logic busy;
    } ppr_printer_in_t;

    // a committed host write for the control path
    typedef struct packed {
        logic       load;
        logic [4:0] bits;
    } ppr_ctrl_write_t;

    // address decode, used by both the read and the write path
    function automatic ppr_target_t ppr_decode(input logic [1:0] addr, input logic is_write);
        ppr_target_t tgt;
        tgt = PPR_TGT_NONE;
        unique case (addr)
            ADDR_DATA:    tgt = PPR_TGT_DATA;
            ADDR_STATUS:  tgt = is_write ? PPR_TGT_NONE : PPR_TGT_STATUS;
            ADDR_CONTROL: tgt = PPR_TGT_CONTROL;
            ADDR_INVALID: tgt = PPR_TGT_NONE;
        endcase
        return tgt;
    endfunction : ppr_decode

endpackage : ppr_pkg

`default_nettype wire

// ### ppr_status_sense.sv
// ppr_status_sense: assembles the read-only status byte from the printer inputs.
// assumes the inputs are already synchronous; the byte is registered by the read path.
`default_nettype none

module ppr_status_sense (
    input  wire ppr_pkg::ppr_printer_in_t pins,
    output logic [7:0]                    status_byte
);

    // low three bits fixed high; busy is the only inverted input
    assign status_byte = ppr_pkg::ST_ONES
                       | (8'(pins.fault_n)   << ppr_pkg::ST_FAULT)
                       | (8'(pins.online)    << ppr_pkg::ST_ONLINE)
                       | (8'(pins.media_out) << ppr_pkg::ST_MEDIA)
                       | (8'(pins.ack_n)     << ppr_pkg::ST_DONE)
                       | (8'(!pins.busy)     << ppr_pkg::ST_BUSY);

endmodule : ppr_status_sense

`default_nettype wire

// ### ppr_ctrl_pins.sv
// ppr_ctrl_pins: control register flops driving the printer control pins and the irq pin.
// assumes writes arrive as one-cycle load pulses from the host register logic.
`default_nettype none

module ppr_ctrl_pins (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire ppr_pkg::ppr_ctrl_write_t wr,
    input  wire logic                     ack_n,
    output logic                          data_strobe_out_n,
    output logic                          auto_feed_n,
    output logic                          printer_init_n,
    output logic                          select_in_n,
    output logic                          printer_irq,
    output logic                          printer_irq_oe,
    output logic [7:0]                    readback
);

    logic [4:0] ctl;
    logic       irq_level;

    // a set control bit 0 to 3 pulls its pin low, a set bit 4 raises the irq enable; pins come straight from these flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl <= ppr_pkg::CTL_RESET;
        end else if (wr.load) begin
            ctl <= wr.bits;
        end
    end

    // irq pin follows the acknowledge pulse, inverted so a done printer raises it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_level <= 1'h0;
        end else begin
            irq_level <= !ack_n;
        end
    end

    assign data_strobe_out_n = !ctl[ppr_pkg::CTL_STROBE];
    assign auto_feed_n       = !ctl[ppr_pkg::CTL_FEED];
    assign printer_init_n    = !ctl[ppr_pkg::CTL_INIT];
    assign select_in_n       = !ctl[ppr_pkg::CTL_SELECT];
    assign printer_irq       = irq_level;
    assign printer_irq_oe    = ctl[ppr_pkg::CTL_IRQ_EN];

    // read back from the pin levels, not a separate copy; top bits fixed high
    assign readback = ppr_pkg::CTL_ONES
                    | {3'h0, ctl[ppr_pkg::CTL_IRQ_EN], !select_in_n, !printer_init_n,
                       !auto_feed_n, !data_strobe_out_n};

endmodule : ppr_ctrl_pins

`default_nettype wire

// ### ppr_port_regs.sv
// ppr_port_regs: host register block of a printer parallel port with data, status and control registers.
// assumes host strobes, select and address are synchronous to clk and held per the bus timing.
//
// Operation
// - registers respond only while the port select input is held low
// - read returns data at 00, status at 01, control at 10; 11 invalid
// - write loads data at 00 and control at 10; 01 and 11 invalid
// - eight-bit data register drives printer data lines, bit n to line n
// - status register is read-only; its three low bits always read one
// - status bit 3 shows the fault input level, not inverted
// - status bit 4 shows the printer-online input level
// - status bit 5 shows the media-out input level
// - status bit 6 shows the acknowledge input level
// - status bit 7 shows the inverse of the busy input
// - control bit 0 set drives data strobe low, clear drives it high
// - control bit 1 set drives auto-feed low, clear drives it high
// - control bit 2 set drives printer reset low, clear drives it high
// - control bit 3 set drives select-in low, clear drives it high
// - control bit 4 enables the interrupt output pin
// - control bits 5 to 7 always read as one
// - control read returns the present control pin levels
`default_nettype none

module ppr_port_regs #(
    parameter int PORT_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // host side
    input  wire logic              parallel_port_select_n,
    input  wire logic [1:0]        host_addr,
    input  wire logic              host_read_strobe_n,
    input  wire logic              host_write_strobe_n,
    input  wire logic [7:0]        host_data_in,
    output logic      [7:0]        host_data_out,
    output logic                   host_data_oe,
    // printer side
    output logic      [PORT_W-1:0] printer_data_out,
    output logic                   data_strobe_out_n,
    output logic                   auto_feed_n,
    output logic                   printer_init_n,
    output logic                   select_in_n,
    output logic                   printer_irq,
    output logic                   printer_irq_oe,
    input  wire logic              printer_fault_n,
    input  wire logic              printer_online,
    input  wire logic              media_out,
    input  wire logic              printer_ack_n,
    input  wire logic              printer_busy
);

    // the register map is byte wide; a wider or narrower port has no meaning here
    if (PORT_W != 8) begin : g_width_check
        $error("ppr_port_regs: PORT_W must be 8");
    end

    typedef enum logic {
        PPR_WR_IDLE,
        PPR_WR_HOLD
    } ppr_wr_state_t;

    ppr_pkg::ppr_host_req_t   req;
    ppr_pkg::ppr_printer_in_t pins_in;
    ppr_pkg::ppr_ctrl_write_t ctrl_wr;
    ppr_pkg::ppr_target_t     rd_target;
    ppr_pkg::ppr_target_t     commit_target;
    ppr_wr_state_t            wr_state;
    ppr_wr_state_t            next_wr_state;
    logic [1:0]               hold_addr;
    logic [7:0]               hold_data;
    logic [PORT_W-1:0]        printer_data;
    logic [7:0]               status_byte;
    logic [7:0]               ctrl_readback;
    logic [7:0]               next_read_data;
    logic [7:0]               read_data;
    logic                     rd_active;
    logic                     wr_active;
    logic                     commit;
    logic                     commit_data;
    logic                     commit_ctrl;

    // bundle the host pins so the decode sees one coherent sample
    assign req.sel_n = parallel_port_select_n;
    assign req.rd_n  = host_read_strobe_n;
    assign req.wr_n  = host_write_strobe_n;
    assign req.addr  = host_addr;
    assign req.wdata = host_data_in;

    assign pins_in.fault_n   = printer_fault_n;
    assign pins_in.online    = printer_online;
    assign pins_in.media_out = media_out;
    assign pins_in.ack_n     = printer_ack_n;
    assign pins_in.busy      = printer_busy;

    // a cycle only counts with select low and exactly one strobe low
    assign rd_active = !req.sel_n && !req.rd_n && req.wr_n;
    assign wr_active = !req.sel_n && !req.wr_n && req.rd_n;

    // write cycle: follow the bus while the strobe is low, commit when it is released,
    // so the value that counts is the one sampled at the last clock edge before the strobe is released
    always_comb begin
        next_wr_state = wr_state;
        unique case (wr_state)
            PPR_WR_IDLE: begin
                if (wr_active) begin
                    next_wr_state = PPR_WR_HOLD;
                end
            end
            PPR_WR_HOLD: begin
                if (!wr_active) begin
                    next_wr_state = PPR_WR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_state <= PPR_WR_IDLE;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    // capture address and data on every cycle of the strobe; the last sample wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_addr <= ppr_pkg::ADDR_INVALID;
            hold_data <= ppr_pkg::DATA_RESET;
        end else if (wr_active) begin
            hold_addr <= req.addr;
            hold_data <= req.wdata;
        end
    end

    // one-cycle commit pulse; status and the fourth address decode to no target
    assign commit        = (wr_state == PPR_WR_HOLD) && !wr_active;
    assign commit_target = ppr_pkg::ppr_decode(hold_addr, 1'h1);
    assign commit_data   = commit && (commit_target == ppr_pkg::PPR_TGT_DATA);
    assign commit_ctrl   = commit && (commit_target == ppr_pkg::PPR_TGT_CONTROL);

    assign ctrl_wr.load = commit_ctrl;
    assign ctrl_wr.bits = hold_data[4:0];

    // data register feeds the printer lines directly, bit n to line n
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            printer_data <= ppr_pkg::DATA_RESET;
        end else if (commit_data) begin
            printer_data <= hold_data[PORT_W-1:0];
        end
    end

    assign printer_data_out = printer_data;

    ppr_status_sense u_status (
        .pins        (pins_in),
        .status_byte (status_byte)
    );

    ppr_ctrl_pins u_ctrl (
        .clk               (clk),
        .rst               (rst),
        .wr                (ctrl_wr),
        .ack_n             (printer_ack_n),
        .data_strobe_out_n (data_strobe_out_n),
        .auto_feed_n       (auto_feed_n),
        .printer_init_n    (printer_init_n),
        .select_in_n       (select_in_n),
        .printer_irq       (printer_irq),
        .printer_irq_oe    (printer_irq_oe),
        .readback          (ctrl_readback)
    );

    // read select; an invalid or idle read registers zero so nothing stale leaks out
    assign rd_target = ppr_pkg::ppr_decode(req.addr, 1'h0);
    assign next_read_data =
        !rd_active                              ? ppr_pkg::READ_IDLE :
        (rd_target == ppr_pkg::PPR_TGT_DATA)    ? 8'(printer_data) :
        (rd_target == ppr_pkg::PPR_TGT_STATUS)  ? status_byte :
        (rd_target == ppr_pkg::PPR_TGT_CONTROL) ? ctrl_readback :
                                                  ppr_pkg::READ_IDLE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_data <= ppr_pkg::READ_IDLE;
        end else begin
            read_data <= next_read_data;
        end
    end

    // the bus is driven only for a valid read; deselect or an invalid address leaves it free
    assign host_data_out = read_data;
    assign host_data_oe  = rd_active && (rd_target != ppr_pkg::PPR_TGT_NONE);

    // checks on the host read path and on committed writes
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic rd_status;
    logic rd_control;
    assign rd_status  = rd_active && (req.addr == ppr_pkg::ADDR_STATUS);
    assign rd_control = rd_active && (req.addr == ppr_pkg::ADDR_CONTROL);

    property p_deselect_quiet;
        req.sel_n |-> !host_data_oe;
    endproperty
    a_deselect_quiet: assert property (p_deselect_quiet)
        else $error("bus driven while port deselected");

    property p_invalid_read_quiet;
        rd_active && (req.addr == ppr_pkg::ADDR_INVALID) |-> !host_data_oe ##1 host_data_out == 8'h00;
    endproperty
    a_invalid_read_quiet: assert property (p_invalid_read_quiet)
        else $error("invalid read drove data");

    property p_read_data_reg;
        rd_active && (req.addr == ppr_pkg::ADDR_DATA) |=> host_data_out == $past(printer_data);
    endproperty
    a_read_data_reg: assert property (p_read_data_reg)
        else $error("data register read mismatch");

    property p_status_layout;
        rd_status |=> host_data_out[2:0] == 3'h7
            && host_data_out[3] == $past(printer_fault_n)
            && host_data_out[4] == $past(printer_online)
            && host_data_out[5] == $past(media_out)
            && host_data_out[6] == $past(printer_ack_n);
    endproperty
    a_status_layout: assert property (p_status_layout)
        else $error("status byte layout wrong");

    property p_busy_inverted;
        rd_status |=> host_data_out[7] == !$past(printer_busy);
    endproperty
    a_busy_inverted: assert property (p_busy_inverted)
        else $error("busy status not inverted");

    property p_data_write;
        wr_active && (req.addr == ppr_pkg::ADDR_DATA) ##1 !wr_active
            |=> printer_data_out == $past(req.wdata, 2);
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("data lines did not take the written byte");

    property p_invalid_write_stable;
        commit && (hold_addr == ppr_pkg::ADDR_STATUS || hold_addr == ppr_pkg::ADDR_INVALID)
            |=> $stable(printer_data_out) && $stable(data_strobe_out_n) && $stable(auto_feed_n)
                && $stable(printer_init_n) && $stable(select_in_n) && $stable(printer_irq_oe);
    endproperty
    a_invalid_write_stable: assert property (p_invalid_write_stable)
        else $error("invalid write changed state");

    property p_strobe_polarity;
        commit_ctrl |=> data_strobe_out_n == !$past(hold_data[ppr_pkg::CTL_STROBE])
            && auto_feed_n == !$past(hold_data[ppr_pkg::CTL_FEED]);
    endproperty
    a_strobe_polarity: assert property (p_strobe_polarity)
        else $error("strobe or feed pin polarity wrong");

    property p_init_select_polarity;
        commit_ctrl |=> printer_init_n == !$past(hold_data[ppr_pkg::CTL_INIT])
            && select_in_n == !$past(hold_data[ppr_pkg::CTL_SELECT]);
    endproperty
    a_init_select_polarity: assert property (p_init_select_polarity)
        else $error("init or select-in pin polarity wrong");

    property p_irq_enable;
        commit_ctrl |=> printer_irq_oe == $past(hold_data[ppr_pkg::CTL_IRQ_EN]);
    endproperty
    a_irq_enable: assert property (p_irq_enable)
        else $error("irq enable not applied");

    property p_ctrl_readback;
        rd_control |=> host_data_out[7:5] == 3'h7
            && host_data_out[0] == !$past(data_strobe_out_n)
            && host_data_out[3] == !$past(select_in_n);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control readback does not match pins");

    // a read strobe at a real register turns the bus driver on in the same cycle
    property p_read_enable;
        rd_active && (req.addr != ppr_pkg::ADDR_INVALID) |-> host_data_oe;
    endproperty
    a_read_enable: assert property (p_read_enable)
        else $error("valid read left the bus undriven");

    // read strobe high keeps the bus free, so a host write never fights our driver
    property p_no_read_no_drive;
        req.rd_n |-> !host_data_oe;
    endproperty
    a_no_read_no_drive: assert property (p_no_read_no_drive)
        else $error("bus driven without a read strobe");

    // outside a read the output flops fall back to zero, so no stale byte lingers
    property p_idle_read_zero;
        !rd_active |=> host_data_out == ppr_pkg::READ_IDLE;
    endproperty
    a_idle_read_zero: assert property (p_idle_read_zero)
        else $error("read data left over outside a read");

    // the holding flops track the bus on every strobe cycle
    property p_hold_tracks_bus;
        wr_active |=> hold_data == $past(req.wdata) && hold_addr == $past(req.addr);
    endproperty
    a_hold_tracks_bus: assert property (p_hold_tracks_bus)
        else $error("write holding flops missed the bus");

    // a deselected idle port never commits on the next edge
    property p_deselect_no_commit;
        req.sel_n && (wr_state == PPR_WR_IDLE) |=> !commit;
    endproperty
    a_deselect_no_commit: assert property (p_deselect_no_commit)
        else $error("commit without a selected write");

    // data lines move only on a committed data write
    property p_data_only_on_commit;
        !commit_data |=> $stable(printer_data_out);
    endproperty
    a_data_only_on_commit: assert property (p_data_only_on_commit)
        else $error("data lines changed without a data write");

    // control pins move only on a committed control write
    property p_ctrl_only_on_commit;
        !commit_ctrl |=> $stable(data_strobe_out_n) && $stable(auto_feed_n) && $stable(printer_init_n)
            && $stable(select_in_n) && $stable(printer_irq_oe);
    endproperty
    a_ctrl_only_on_commit: assert property (p_ctrl_only_on_commit)
        else $error("control pins changed without a control write");

    // the other readback bits come from the pins as well
    property p_ctrl_readback_rest;
        rd_control |=> host_data_out[1] == !$past(auto_feed_n)
            && host_data_out[2] == !$past(printer_init_n)
            && host_data_out[4] == $past(printer_irq_oe);
    endproperty
    a_ctrl_readback_rest: assert property (p_ctrl_readback_rest)
        else $error("control readback bits 1, 2 or 4 wrong");

    // irq level is the acknowledge inverted one clock late; the enable only gates the driver
    property p_irq_follows_ack;
        1'h1 |=> printer_irq == !$past(printer_ack_n);
    endproperty
    a_irq_follows_ack: assert property (p_irq_follows_ack)
        else $error("irq pin does not follow the acknowledge input");

endmodule : ppr_port_regs

`default_nettype wire

// ### ppr_printer_model.sv
// ppr_printer_model: behavioural printer on the far side of the port pins.
// assumes the bench sets the sensed levels; they reach the pins at the next falling clock edge.
`default_nettype none

module ppr_printer_model (
    input  wire logic                     clk,
    input  wire logic [7:0]               data_lines,
    input  wire logic                     data_strobe_out_n,
    input  wire ppr_pkg::ppr_printer_in_t levels,
    output var  ppr_pkg::ppr_printer_in_t pins,
    output logic [7:0]                    last_byte
);
    timeunit 1ns;
    timeprecision 1ns;

    // status levels move on the falling edge so the port never samples them mid-change
    always @(negedge clk) pins <= levels;

    // a printer takes the byte when the strobe drops, so the data lines must already be settled
    always @(negedge data_strobe_out_n) last_byte <= data_lines;

endmodule : ppr_printer_model

`default_nettype wire

// ### tb_printer_parallel_port_regs.sv
// tb_printer_parallel_port_regs: self-checking bench for the printer port register block.
// assumes the package and design files are compiled first; the printer is a behavioural model.
`default_nettype none

module tb_printer_parallel_port_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     sel_n = 1'b1;
    logic                     rd_n = 1'b1;
    logic                     wr_n = 1'b1;
    logic [1:0]               addr = 2'h0;
    logic [7:0]               wdata = 8'h00;
    logic [7:0]               rdata;
    logic                     oe;
    logic [7:0]               pdata;
    logic                     stb_n;
    logic                     feed_n;
    logic                     init_n;
    logic                     select_in_n_n;
    logic                     irq;
    logic                     irq_oe;
    logic [7:0]               last_byte;
    ppr_pkg::ppr_printer_in_t levels = 5'h1E;
    ppr_pkg::ppr_printer_in_t pins;
    int                       n_errors = 0;
    int                       n_tests = 0;
    int                       cycles = 0;
    logic [7:0]               rv;
    logic                     ro;
    logic [7:0]               vals [5] = '{8'h5A, 8'hA5, 8'hFF, 8'h00, 8'h01};
    logic [7:0]               ctls [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'hFF, 8'h1F, 8'h00};
    logic [4:0]               pats [8] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1F, 5'h15};

    // control pins seen as the bits that should have set them
    wire  [7:0]               pin_vec = {3'h0, irq_oe, ~select_in_n_n, ~init_n, ~feed_n, ~stb_n};

    // 20 MHz clock
    always #25 clk = ~clk;

    ppr_port_regs #(.PORT_W(8)) dut_u (
        .clk(clk), .rst(rst), .parallel_port_select_n(sel_n), .host_addr(addr),
        .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .host_data_in(wdata),
        .host_data_out(rdata), .host_data_oe(oe), .printer_data_out(pdata),
        .data_strobe_out_n(stb_n), .auto_feed_n(feed_n), .printer_init_n(init_n),
        .select_in_n(select_in_n_n), .printer_irq(irq), .printer_irq_oe(irq_oe),
        .printer_fault_n(pins.fault_n), .printer_online(pins.online), .media_out(pins.media_out),
        .printer_ack_n(pins.ack_n), .printer_busy(pins.busy)
    );

    ppr_printer_model printer_u (
        .clk(clk), .data_lines(pdata), .data_strobe_out_n(stb_n), .levels(levels),
        .pins(pins), .last_byte(last_byte)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // write cycle: strobe low for one edge, committed at the release edge, then one deselected edge
    task automatic wr(input logic s_n, input logic [1:0] a, input logic [7:0] d);
        sel_n = s_n;
        addr = a;
        wdata = d;
        wr_n = 1'b0;
        @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        sel_n = 1'b1;
        @(negedge clk);
    endtask : wr

    // read cycle: enable looked at while the strobe is low, data one edge later
    task automatic rd(input logic s_n, input logic [1:0] a, output logic [7:0] d, output logic o);
        sel_n = s_n;
        addr = a;
        rd_n = 1'b0;
        #1 o = oe;
        @(negedge clk);
        d = rdata;
        rd_n = 1'b1;
        sel_n = 1'b1;
        @(negedge clk);
    endtask : rd

    task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input logic exp_oe);
        rd(1'b0, a, rv, ro);
        chk("read data", exp, rv);
        chk("read enable", {7'h0, exp_oe}, {7'h0, ro});
    endtask : rchk

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // a hang stops well past the 145 or so cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("data lines", 8'h00, pdata);
        chk("control pins", 8'h00, pin_vec);
        foreach (vals[i]) begin
            wr(1'b0, 2'h0, vals[i]);
            chk("data lines", vals[i], pdata);
            rchk(2'h0, vals[i], 1'b1);
        end
        foreach (ctls[i]) begin
            wr(1'b0, 2'h2, ctls[i]);
            chk("control pins", ctls[i] & 8'h1F, pin_vec);
            rchk(2'h2, 8'hE0 | ctls[i], 1'b1);
        end
        // the printer must latch what the data lines held when the strobe fell
        wr(1'b0, 2'h0, 8'h3C);
        wr(1'b0, 2'h2, 8'h01);
        chk("printer byte", 8'h3C, last_byte);
        foreach (pats[i]) begin
            levels = pats[i];
            repeat (2) @(negedge clk);
            rchk(2'h1, {~pats[i][0], pats[i][1], pats[i][2], pats[i][3], pats[i][4], 3'h7}, 1'b1);
        end
        // refused and invalid accesses must leave everything alone
        wr(1'b0, 2'h0, 8'h5A);
        wr(1'b0, 2'h2, 8'h03);
        wr(1'b0, 2'h1, 8'hFF);
        wr(1'b0, 2'h3, 8'hFF);
        wr(1'b1, 2'h0, 8'hFF);
        wr(1'b1, 2'h2, 8'hFF);
        chk("data lines", 8'h5A, pdata);
        chk("control pins", 8'h03, pin_vec);
        rchk(2'h1, 8'h2F, 1'b1);
        rchk(2'h3, 8'h00, 1'b0);
        rd(1'b1, 2'h0, rv, ro);
        chk("deselected enable", 8'h00, {7'h0, ro});
        chk("deselected data", 8'h00, rv);
        // interrupt pin follows the inverted acknowledge; the enable only switches its driver
        wr(1'b0, 2'h2, 8'h10);
        levels = 5'h1D;
        repeat (3) @(negedge clk);
        chk("irq pin", 8'h01, {7'h0, irq});
        chk("irq enable", 8'h01, {7'h0, irq_oe});
        levels = 5'h1F;
        repeat (3) @(negedge clk);
        chk("irq pin", 8'h00, {7'h0, irq});
        wr(1'b0, 2'h2, 8'h00);
        chk("irq enable", 8'h00, {7'h0, irq_oe});
        final_report();
    end

endmodule : tb_printer_parallel_port_regs

`default_nettype wire
